// File: hdl/scrb_pkg.sv
// constants and types shared by the serial configuration register bank
package scrb_pkg;

    // serial frame layout: read flag, 8 unused bits, 15-bit address, then data bytes
    localparam int ADDR_W    = 15;
    localparam int CMD_BITS  = 24;
    localparam int BYTE_W    = 8;
    localparam int COEF_W    = 16;
    localparam int NUM_COEF  = 18;
    localparam int CNT_W     = 5;
    localparam int IDX_W     = 5;

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_CONFIG      = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM   = 15'h0357;
    localparam logic [ADDR_W-1:0] ADDR_FILTER_MODE = 15'h0400;
    localparam logic [ADDR_W-1:0] ADDR_STEP        = 15'h0001;

    // coefficient base addresses, a0..a8 then b0..b8; low byte at base, high at base+1
    localparam logic [ADDR_W-1:0] COEF_ADDR [NUM_COEF] = '{
        15'h0418, 15'h041a, 15'h041c, 15'h041e, 15'h0420,
        15'h0423, 15'h0425, 15'h0427, 15'h0429,
        15'h0448, 15'h044a, 15'h044c, 15'h044e, 15'h0450,
        15'h0453, 15'h0455, 15'h0457, 15'h0459
    };

    // configuration register fields and reset values
    localparam int CFG_RESET_BIT = 7;
    localparam int CFG_DIR_BIT   = 5;
    localparam int CFG_RDPIN_BIT = 4;
    localparam logic [7:0]  CFG_STORE_MASK    = 8'h6f;
    localparam logic [7:0]  CONFIG_RESET      = 8'h30;
    localparam logic [7:0]  FILTER_MODE_RESET = 8'h00;
    localparam logic [7:0]  GAIN_TRIM_RESET   = 8'h00;
    localparam logic [15:0] COEF_RESET        = 16'h0000;
    localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

    // chip reset duration, longest time so rounded down
    localparam int CLK_PERIOD_PS = 10000;
    localparam int RESET_TIME_NS = 750;
    localparam int RESET_CYCLES  = (RESET_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int RST_CNT_W     = 8;

    // fuse value settles through the two-stage synchroniser first
    localparam logic [1:0] FUSE_LOAD_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        SCRB_IDLE = 2'b00,
        SCRB_CMD  = 2'b01,
        SCRB_DATA = 2'b10,
        SCRB_SKIP = 2'b11
    } scrb_state_t;

endpackage

// File: hdl/scrb_top.sv
// serial host register bank: configuration register, gain trim, filter mode and coefficients
`timescale 1ns/1ps

module scrb_top (
    input  wire logic                                        i_mclk,
    input  wire logic                                        i_resetn,
    input  wire logic                                        i_sclk,
    input  wire logic                                        i_csn,
    input  wire logic                                        i_sdi,
    input  wire logic [7:0]                                  i_fuse_gain_trim,
    output logic                                             o_sdo,
    output logic                                             o_sdo_oe,
    output logic                                             o_chip_reset,
    output logic                                             o_address_direction,
    output logic [7:0]                                       o_gain_trim,
    output logic [7:0]                                       o_filter_mode,
    output logic [scrb_pkg::NUM_COEF*scrb_pkg::COEF_W-1:0]   o_filter_coefs
);

    // pin synchronisers; stage 0 feeds only stage 1
    logic [2:0]               sclk_q;
    logic [1:0]               csn_q;
    logic [1:0]               sdi_q;
    logic [7:0]               fuse_q0;
    logic [7:0]               fuse_q1;
    logic                     sclk_rise;
    logic                     sclk_fall;

    // serial engine state
    scrb_pkg::scrb_state_t    state_r, state_nxt;
    logic [scrb_pkg::CNT_W-1:0]    bitcnt_r, bitcnt_nxt;
    logic [scrb_pkg::CMD_BITS-2:0] cmd_r, cmd_nxt;
    logic [7:0]               rx_r, rx_nxt;
    logic [7:0]               tx_r, tx_nxt;
    logic [scrb_pkg::ADDR_W-1:0]   addr_r, addr_nxt;
    logic                     rd_r, rd_nxt;
    logic                     sdo_r, sdo_nxt;
    logic                     wr_en;
    logic [scrb_pkg::ADDR_W-1:0]   wr_addr;
    logic [7:0]               wr_data;

    // register file state
    logic [7:0]               cfg_r, cfg_nxt;
    logic [7:0]               gain_r, gain_nxt;
    logic [7:0]               fmode_r, fmode_nxt;
    logic [scrb_pkg::COEF_W-1:0]   coef_r   [scrb_pkg::NUM_COEF];
    logic [scrb_pkg::COEF_W-1:0]   coef_nxt [scrb_pkg::NUM_COEF];
    logic                     busy_r, busy_nxt;
    logic [scrb_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
    logic [1:0]               fuse_cnt_r, fuse_cnt_nxt;

    // coefficient decode: {hit, high byte, index}
    function automatic logic [scrb_pkg::IDX_W+1:0] coef_lookup(
        input logic [scrb_pkg::ADDR_W-1:0] a
    );
        logic [scrb_pkg::IDX_W+1:0] res;
        res = '0;
        for (int i = 0; i < scrb_pkg::NUM_COEF; i++) begin
            if (a == scrb_pkg::COEF_ADDR[i]) begin
                res = {1'b1, 1'b0, scrb_pkg::IDX_W'(i)};
            end
            if (a == scrb_pkg::COEF_ADDR[i] + scrb_pkg::ADDR_STEP) begin
                res = {1'b1, 1'b1, scrb_pkg::IDX_W'(i)};
            end
        end
        return res;
    endfunction

    // streaming address step, direction from the config register
    function automatic logic [scrb_pkg::ADDR_W-1:0] step_addr(
        input logic [scrb_pkg::ADDR_W-1:0] a,
        input logic                        up
    );
        return up ? a + scrb_pkg::ADDR_STEP : a - scrb_pkg::ADDR_STEP;
    endfunction

    // read mux; unmapped addresses read zero
    function automatic logic [7:0] read_byte(input logic [scrb_pkg::ADDR_W-1:0] a);
        logic [7:0]                  res;
        logic [scrb_pkg::IDX_W+1:0]  hit;
        logic [scrb_pkg::COEF_W-1:0] coef_word;
        res       = scrb_pkg::UNMAPPED_READ;
        hit       = coef_lookup(a);
        coef_word = scrb_pkg::COEF_RESET;
        case (a)
            scrb_pkg::ADDR_CONFIG: begin
                res = cfg_r;
                res[scrb_pkg::CFG_RESET_BIT] = busy_r;
                res[scrb_pkg::CFG_RDPIN_BIT] = 1'b1;
            end
            scrb_pkg::ADDR_GAIN_TRIM: begin
                res = gain_r;
            end
            scrb_pkg::ADDR_FILTER_MODE: begin
                res = fmode_r;
            end
            default: begin
                // coefficient words are read one byte lane at a time
                if (hit[scrb_pkg::IDX_W+1]) begin
                    coef_word = coef_r[hit[scrb_pkg::IDX_W-1:0]];
                    if (hit[scrb_pkg::IDX_W]) begin
                        res = coef_word[scrb_pkg::COEF_W-1:scrb_pkg::BYTE_W];
                    end else begin
                        res = coef_word[scrb_pkg::BYTE_W-1:0];
                    end
                end
            end
        endcase
        return res;
    endfunction

    // two flops on every pin; sclk gets a third for edge detection
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sclk_q  <= '0;
            csn_q   <= 2'h3;
            sdi_q   <= '0;
            fuse_q0 <= '0;
            fuse_q1 <= '0;
        end else begin
            sclk_q  <= {sclk_q[1:0], i_sclk};
            csn_q   <= {csn_q[0], i_csn};
            sdi_q   <= {sdi_q[0], i_sdi};
            fuse_q0 <= i_fuse_gain_trim;
            fuse_q1 <= fuse_q0;
        end
    end

    // limitation: each sclk phase must last at least three mclk cycles
    assign sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = ~sclk_q[1] & sclk_q[2];

    // serial engine: sample on rising sclk, shift read data on falling sclk
    always_comb begin
        state_nxt  = state_r;
        bitcnt_nxt = bitcnt_r;
        cmd_nxt    = cmd_r;
        rx_nxt     = rx_r;
        tx_nxt     = tx_r;
        addr_nxt   = addr_r;
        rd_nxt     = rd_r;
        sdo_nxt    = sdo_r;
        wr_en      = 1'b0;
        wr_addr    = addr_r;
        wr_data    = rx_r;
        if (busy_r) begin
            // frames during chip reset are dropped
            state_nxt  = scrb_pkg::SCRB_SKIP;
            bitcnt_nxt = '0;
        end else if (csn_q[1]) begin
            state_nxt  = scrb_pkg::SCRB_IDLE;
            bitcnt_nxt = '0;
            sdo_nxt    = 1'b0;
        end else begin
            case (state_r)
                scrb_pkg::SCRB_IDLE: begin
                    state_nxt  = scrb_pkg::SCRB_CMD;
                    bitcnt_nxt = '0;
                end
                scrb_pkg::SCRB_CMD: begin
                    if (sclk_rise) begin
                        cmd_nxt    = {cmd_r[scrb_pkg::CMD_BITS-3:0], sdi_q[1]};
                        bitcnt_nxt = bitcnt_r + 1'b1;
                        // last command bit: address complete, first read byte fetched
                        if (bitcnt_r == scrb_pkg::CNT_W'(scrb_pkg::CMD_BITS - 1)) begin
                            addr_nxt   = {cmd_r[scrb_pkg::ADDR_W-2:0], sdi_q[1]};
                            rd_nxt     = cmd_r[scrb_pkg::CMD_BITS-2];
                            tx_nxt     = read_byte({cmd_r[scrb_pkg::ADDR_W-2:0], sdi_q[1]});
                            bitcnt_nxt = '0;
                            state_nxt  = scrb_pkg::SCRB_DATA;
                        end
                    end
                end
                scrb_pkg::SCRB_DATA: begin
                    if (sclk_rise) begin
                        rx_nxt     = {rx_r[scrb_pkg::BYTE_W-2:0], sdi_q[1]};
                        bitcnt_nxt = bitcnt_r + 1'b1;
                        if (bitcnt_r == scrb_pkg::CNT_W'(scrb_pkg::BYTE_W - 1)) begin
                            bitcnt_nxt = '0;
                            wr_en      = ~rd_r;
                            wr_data    = {rx_r[scrb_pkg::BYTE_W-2:0], sdi_q[1]};
                            addr_nxt   = step_addr(addr_r, cfg_r[scrb_pkg::CFG_DIR_BIT]);
                            tx_nxt     = read_byte(addr_nxt);
                        end
                    end else if (sclk_fall) begin
                        // read data leaves only on the output line
                        sdo_nxt = tx_r[scrb_pkg::BYTE_W-1];
                        tx_nxt  = {tx_r[scrb_pkg::BYTE_W-2:0], 1'b0};
                    end
                end
                scrb_pkg::SCRB_SKIP: begin
                    bitcnt_nxt = '0;
                end
                default: begin
                    state_nxt = scrb_pkg::SCRB_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r  <= scrb_pkg::SCRB_IDLE;
            bitcnt_r <= '0;
            cmd_r    <= '0;
            rx_r     <= '0;
            tx_r     <= '0;
            addr_r   <= '0;
            rd_r     <= 1'b0;
            sdo_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            cmd_r    <= cmd_nxt;
            rx_r     <= rx_nxt;
            tx_r     <= tx_nxt;
            addr_r   <= addr_nxt;
            rd_r     <= rd_nxt;
            sdo_r    <= sdo_nxt;
        end
    end

    // register file: writes, chip reset sequence, fuse load
    // the fuse copy repeats for a few cycles so the synchroniser has settled
    always_comb begin
        logic [scrb_pkg::IDX_W+1:0] hit;
        logic [scrb_pkg::IDX_W-1:0] idx;
        hit          = coef_lookup(wr_addr);
        idx          = hit[scrb_pkg::IDX_W-1:0];
        cfg_nxt      = cfg_r;
        gain_nxt     = gain_r;
        fmode_nxt    = fmode_r;
        coef_nxt     = coef_r;
        busy_nxt     = busy_r;
        rst_cnt_nxt  = rst_cnt_r;
        fuse_cnt_nxt = fuse_cnt_r;
        if (busy_r) begin
            cfg_nxt     = scrb_pkg::CONFIG_RESET & scrb_pkg::CFG_STORE_MASK;
            gain_nxt    = scrb_pkg::GAIN_TRIM_RESET;
            fmode_nxt   = scrb_pkg::FILTER_MODE_RESET;
            for (int i = 0; i < scrb_pkg::NUM_COEF; i++) begin
                coef_nxt[i] = scrb_pkg::COEF_RESET;
            end
            rst_cnt_nxt = rst_cnt_r + 1'b1;
            // finish within the fixed reset time
            if (rst_cnt_r == scrb_pkg::RST_CNT_W'(scrb_pkg::RESET_CYCLES - 1)) begin
                busy_nxt     = 1'b0;
                fuse_cnt_nxt = scrb_pkg::FUSE_LOAD_CYCLES;
            end
        end else begin
            if (fuse_cnt_r != '0) begin
                gain_nxt     = fuse_q1;
                fuse_cnt_nxt = fuse_cnt_r - 1'b1;
            end
            if (wr_en) begin
                case (wr_addr)
                    scrb_pkg::ADDR_CONFIG: begin
                        if (wr_data[scrb_pkg::CFG_RESET_BIT]) begin
                            busy_nxt    = 1'b1;
                            rst_cnt_nxt = '0;
                        end else begin
                            // trigger and indicator bits are never stored
                            cfg_nxt = wr_data & scrb_pkg::CFG_STORE_MASK;
                        end
                    end
                    scrb_pkg::ADDR_GAIN_TRIM: begin
                        gain_nxt = wr_data;
                    end
                    scrb_pkg::ADDR_FILTER_MODE: begin
                        fmode_nxt = wr_data;
                    end
                    default: begin
                        if (hit[scrb_pkg::IDX_W+1]) begin
                            if (hit[scrb_pkg::IDX_W]) begin
                                coef_nxt[idx][scrb_pkg::COEF_W-1:scrb_pkg::BYTE_W] = wr_data;
                            end else begin
                                coef_nxt[idx][scrb_pkg::BYTE_W-1:0] = wr_data;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // config resets to direction up, filter mode to zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_r      <= scrb_pkg::CONFIG_RESET & scrb_pkg::CFG_STORE_MASK;
            gain_r     <= scrb_pkg::GAIN_TRIM_RESET;
            fmode_r    <= scrb_pkg::FILTER_MODE_RESET;
            for (int i = 0; i < scrb_pkg::NUM_COEF; i++) begin
                coef_r[i] <= scrb_pkg::COEF_RESET;
            end
            busy_r     <= 1'b0;
            rst_cnt_r  <= '0;
            fuse_cnt_r <= scrb_pkg::FUSE_LOAD_CYCLES;
        end else begin
            cfg_r      <= cfg_nxt;
            gain_r     <= gain_nxt;
            fmode_r    <= fmode_nxt;
            coef_r     <= coef_nxt;
            busy_r     <= busy_nxt;
            rst_cnt_r  <= rst_cnt_nxt;
            fuse_cnt_r <= fuse_cnt_nxt;
        end
    end

    // outputs; sdo drives only in the data phase of a read
    assign o_sdo               = sdo_r;
    assign o_sdo_oe            = rd_r & (state_r == scrb_pkg::SCRB_DATA);
    assign o_chip_reset        = busy_r;
    assign o_address_direction = cfg_r[scrb_pkg::CFG_DIR_BIT];
    assign o_gain_trim         = gain_r;
    assign o_filter_mode       = fmode_r;

    // flatten coefficients, a0 in the low word
    for (genvar g = 0; g < scrb_pkg::NUM_COEF; g++) begin : g_coef
        assign o_filter_coefs[g*scrb_pkg::COEF_W +: scrb_pkg::COEF_W] = coef_r[g];
    end

endmodule

// File: verif/scrb_chk.sv
// concurrent checks on the register bank ports, bound into the top module
`timescale 1ns/1ps

module scrb_chk (
    input wire logic                                           i_mclk,
    input wire logic                                           i_resetn,
    input wire logic                                           i_sclk,
    input wire logic                                           i_csn,
    input wire logic                                           i_sdi,
    input wire logic [7:0]                                     i_fuse_gain_trim,
    input wire logic                                           o_sdo,
    input wire logic                                           o_sdo_oe,
    input wire logic                                           o_chip_reset,
    input wire logic                                           o_address_direction,
    input wire logic [7:0]                                     o_gain_trim,
    input wire logic [7:0]                                     o_filter_mode,
    input wire logic [scrb_pkg::NUM_COEF*scrb_pkg::COEF_W-1:0] o_filter_coefs
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    // length of the current chip reset run, in mclk cycles
    logic [7:0] rst_len_r;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_len_r <= 8'h00;
        end else begin
            rst_len_r <= o_chip_reset ? rst_len_r + 8'h01 : 8'h00;
        end
    end

    // the trigger clears itself after exactly the fixed reset time
    a_reset_self_clear: assert property (
        $fell(o_chip_reset) |-> int'(rst_len_r) == scrb_pkg::RESET_CYCLES)
        else $error("chip reset did not clear after its fixed time");
    // never longer than the time the host waits out
    a_reset_in_time: assert property (
        o_chip_reset |-> int'(rst_len_r) < scrb_pkg::RESET_CYCLES)
        else $error("chip reset ran past its time limit");
    a_regs_cleared: assert property (
        $fell(o_chip_reset) |-> o_filter_mode == 8'h00 && o_filter_coefs == '0)
        else $error("registers not cleared by chip reset");
    a_dir_default: assert property (
        $fell(o_chip_reset) |-> o_address_direction)
        else $error("direction not back to ascending");
    // fuse pass goes through a synchroniser, so allow a few cycles
    a_trim_from_fuse: assert property (
        $fell(o_chip_reset) |-> ##[1:6] o_gain_trim == i_fuse_gain_trim)
        else $error("gain trim not reloaded from fuse");
    a_hold_in_reset: assert property (
        o_chip_reset[*3] |-> $stable(o_filter_mode) && $stable(o_filter_coefs))
        else $error("register changed during chip reset");
    a_idle_hold: assert property (
        i_csn[*5] ##0 (!o_chip_reset && !$past(o_chip_reset))
        |-> $stable(o_filter_mode) && $stable(o_filter_coefs) && $stable(o_address_direction))
        else $error("register changed outside a frame");
    a_oe_idle: assert property (
        i_csn[*5] |-> !o_sdo_oe)
        else $error("read output enabled while deselected");
    // read data only moves after a serial clock fall
    a_sdo_steady: assert property (
        i_sclk[*6] |-> $stable(o_sdo))
        else $error("read data moved while serial clock high");

    c_chip_reset: cover property ($fell(o_chip_reset));
    c_read_phase: cover property ($rose(o_sdo_oe));
    c_coef_write: cover property (!$stable(o_filter_coefs) && !o_chip_reset);
endmodule

bind scrb_top scrb_chk u_chk (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(i_sclk), .i_csn(i_csn), .i_sdi(i_sdi),
    .i_fuse_gain_trim(i_fuse_gain_trim), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_chip_reset(o_chip_reset), .o_address_direction(o_address_direction),
    .o_gain_trim(o_gain_trim), .o_filter_mode(o_filter_mode), .o_filter_coefs(o_filter_coefs)
);

// File: verif/scrb_host.sv
// serial host model: mode 0 frames, command then data bytes, msb first
`timescale 1ns/1ps

module scrb_host (
    input  wire logic i_mclk,
    input  wire logic i_sdo,
    output logic      o_sclk,
    output logic      o_csn,
    output logic      o_sdi
);
    int half = 6; // mclk cycles per sclk phase; raise for a slow host

    initial begin
        o_sclk = 1'b0;
        o_csn  = 1'b1;
        o_sdi  = 1'b0;
    end

    // one whole frame, byte k of the stream in wd/rd bits 8k+7..8k
    // read data from output line
    task automatic frame(input logic rw, input logic [14:0] adr, input int nb,
                         input logic [31:0] wd, output logic [31:0] rd);
        logic [23:0] cmd;
        cmd = {rw, 8'h00, adr};
        rd  = '0;
        @(posedge i_mclk);
        o_csn <= 1'b0;
        repeat (half) @(posedge i_mclk);
        for (int i = 0; i < 24 + 8 * nb; i++) begin
            if (i < 24) o_sdi <= cmd[23-i];
            else if (!rw) o_sdi <= wd[i - 24 - 2 * (i % 8) + 7];
            else o_sdi <= ~o_sdi; // not meaningful, keep it moving
            repeat (half) @(posedge i_mclk);
            if (i >= 24) rd[i - 24 - 2 * (i % 8) + 7] = i_sdo;
            o_sclk <= 1'b1;
            repeat (half) @(posedge i_mclk);
            o_sclk <= 1'b0;
        end
        repeat (half) @(posedge i_mclk);
        o_csn <= 1'b1;
        o_sdi <= ~o_sdi; // released line shows no stale value
        repeat (half) @(posedge i_mclk);
    endtask
endmodule

// File: verif/scrb_top_tb.sv
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps

module scrb_top_tb;
    logic                                           i_mclk;
    logic                                           i_resetn;
    logic                                           sclk, csn, sdi, sdo, sdo_oe, sdo_line;
    logic                                           chip_reset, dir;
    logic [7:0]                                     fuse, trim, fmode;
    logic [scrb_pkg::NUM_COEF*scrb_pkg::COEF_W-1:0] coefs;
    logic [31:0]                                    rd;
    int                                             bad_count = 0;
    int                                             num_checks = 0;

    scrb_top u_dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
        .i_fuse_gain_trim(fuse), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_chip_reset(chip_reset),
        .o_address_direction(dir), .o_gain_trim(trim), .o_filter_mode(fmode),
        .o_filter_coefs(coefs)
    );
    // undriven read line shows the inverse, so a read without enable fails
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    scrb_host u_host (.i_mclk(i_mclk), .i_sdo(sdo_line), .o_sclk(sclk), .o_csn(csn),
                      .o_sdi(sdi));

    task automatic close_out();
        if (bad_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [14:0] a, input int nb, input logic [31:0] d);
        u_host.frame(1'b0, a, nb, d, rd);
    endtask

    task automatic rdc(input logic [14:0] a, input int nb, input logic [31:0] exp);
        u_host.frame(1'b1, a, nb, 32'h0, rd);
        chk($sformatf("read at %h", a), exp, rd);
    endtask

    // free-running 100 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // hang guard, well beyond the expected run of some 17k cycles
    initial begin
        repeat (60000) @(posedge i_mclk);
        bad_count++;
        close_out();
    end

    initial begin
        i_resetn = 1'b0;
        fuse     = 8'h3c;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_mclk);
        chk("direction", 32'h1, {31'h0, dir});
        chk("gain trim", 32'h3c, {24'h0, trim});
        rdc(scrb_pkg::ADDR_CONFIG, 1, 32'h30);
        rdc(scrb_pkg::ADDR_GAIN_TRIM, 1, 32'h3c);
        rdc(scrb_pkg::ADDR_FILTER_MODE, 1, 32'h00);
        rdc(15'h0100, 1, 32'h00);
        wr(scrb_pkg::ADDR_FILTER_MODE, 1, 32'h5a);
        chk("filter mode", 32'h5a, {24'h0, fmode});
        // ascending two-byte stream into every coefficient
        for (int k = 0; k < scrb_pkg::NUM_COEF; k++) begin
            wr(scrb_pkg::COEF_ADDR[k], 2, 32'h0f00 + k * 32'h0111);
            chk("coef", 32'h0f00 + k * 32'h0111, {16'h0, coefs[16*k +: 16]});
        end
        rdc(15'h0418, 2, 32'h0f00);
        // descending mode with a slow host; indicator bit ignores the write
        u_host.half = 9;
        wr(scrb_pkg::ADDR_CONFIG, 1, 32'h00);
        chk("direction", 32'h0, {31'h0, dir});
        rdc(scrb_pkg::ADDR_CONFIG, 1, 32'h10);
        wr(15'h041b, 2, 32'habcd);
        chk("coef a1", 32'hcdab, {16'h0, coefs[31:16]});
        rdc(15'h041b, 2, 32'habcd);
        u_host.half = 6;
        // chip reset with a frame pushed in too early on purpose
        wr(scrb_pkg::ADDR_GAIN_TRIM, 1, 32'h11);
        chk("gain trim", 32'h11, {24'h0, trim});
        fuse <= 8'ha5;
        wr(scrb_pkg::ADDR_CONFIG, 1, 32'h80);
        chk("chip reset", 32'h1, {31'h0, chip_reset});
        wr(scrb_pkg::ADDR_FILTER_MODE, 1, 32'h77);
        chk("filter mode", 32'h00, {24'h0, fmode});
        chk("coefs", 32'h0, {31'h0, |coefs});
        chk("direction", 32'h1, {31'h0, dir});
        chk("gain trim", 32'ha5, {24'h0, trim});
        rdc(scrb_pkg::ADDR_CONFIG, 1, 32'h30);
        wr(scrb_pkg::ADDR_FILTER_MODE, 1, 32'h33);
        chk("filter mode", 32'h33, {24'h0, fmode});
        wr(scrb_pkg::ADDR_CONFIG, 1, 32'h80);
        repeat (80) @(posedge i_mclk);
        chk("chip reset", 32'h0, {31'h0, chip_reset});
        rdc(scrb_pkg::ADDR_FILTER_MODE, 1, 32'h00);
        close_out();
    end
endmodule
